/* File: hdl/ipr_pkg.sv */
// Purpose: shared constants for the interrupt priority registers 10..15
// Assumes: APB data 32 bits, registers 16 bits in the low half of a word
// Notes:   every priority field is 3 bits, code 0 means source disabled

package ipr_pkg;

  // --------------------------------------------------------------
  // register map (byte addresses, one aligned word per register)
  // --------------------------------------------------------------
  localparam int          NUM_REGS    = 6;
  localparam logic [7:0]  OFS_PRIO_10 = 8'h00;
  localparam logic [7:0]  OFS_PRIO_11 = 8'h04;
  localparam logic [7:0]  OFS_PRIO_12 = 8'h08;
  localparam logic [7:0]  OFS_PRIO_13 = 8'h0c;
  localparam logic [7:0]  OFS_PRIO_14 = 8'h10;
  localparam logic [7:0]  OFS_PRIO_15 = 8'h14;

  // --------------------------------------------------------------
  // field layout
  // --------------------------------------------------------------
  localparam int          PRIO_W      = 3;
  localparam int          POS_HI      = 12;
  localparam int          POS_MH      = 8;
  localparam int          POS_ML      = 4;
  localparam int          POS_LO      = 0;
  localparam int          NUM_SRC     = 20;

  // implemented bits of each register
  localparam logic [15:0] MASK_10     = 16'h7777;
  localparam logic [15:0] MASK_11     = 16'h7707;
  localparam logic [15:0] MASK_12     = 16'h7777;
  localparam logic [15:0] MASK_13     = 16'h7777;
  localparam logic [15:0] MASK_14     = 16'h0777;
  localparam logic [15:0] MASK_15     = 16'h7070;

  // --------------------------------------------------------------
  // reset values: each field comes up as 3'b100, level four
  // --------------------------------------------------------------
  localparam logic [2:0]  PRIO_RST    = 3'h4;
  localparam logic [15:0] RST_10      = 16'h4444;
  localparam logic [15:0] RST_11      = 16'h4404;
  localparam logic [15:0] RST_12      = 16'h4444;
  localparam logic [15:0] RST_13      = 16'h4444;
  localparam logic [15:0] RST_14      = 16'h0444;
  localparam logic [15:0] RST_15      = 16'h4040;

  localparam logic [2:0]  PRIO_OFF    = 3'h0;

  // pick one 3-bit field out of a register word
  function automatic logic [2:0] field_get(input logic [15:0] w,
                                           input int          pos);
    field_get = w[pos +: PRIO_W];
  endfunction

  // merge write data into a register under byte strobes and the mask
  function automatic logic [15:0] reg_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be,
                                            input logic [15:0] mask);
    logic [15:0] lane;
    lane      = {{8{be[1]}}, {8{be[0]}}};
    reg_merge = ((wd & lane) | (old & ~lane)) & mask;
  endfunction

endpackage

/* File: hdl/ipr_apb_if.sv */
// Purpose: APB slave front end, zero wait states, registered answers
// Assumes: master keeps request stable until pready is sampled high
// Notes:   pready rises in the access cycle following every setup cycle

`timescale 1ns/100ps

module ipr_apb_if
  import ipr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,        // system clock
  input  wire logic              resetn,     // sync reset, low
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic [ADDR_W-1:0] paddr,      // apb byte address
  input  wire logic [31:0]       rd_word,    // decoded read word
  input  wire logic              addr_hit,   // address is mapped
  output logic                   wr_fire,    // transfer completes now
  output logic [31:0]            prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr     // apb error
);

  logic        setup;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready_q;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // --------------------------------------------------------------
  // answer flops, loaded during the setup cycle
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~addr_hit;
      prdata_q  <= addr_hit ? rd_word : 32'h0000_0000;
    end else begin
      // drop everything after the completing edge so a stale word
      // never looks like an answer to the next transfer
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
  end

endmodule

/* File: hdl/ipr_lvl_cmp.sv */
// Purpose: per-source enable and eligibility against the cpu level
// Assumes: src_req is flag and enable already combined outside
// Notes:   outputs are registered, one cycle behind their inputs

`timescale 1ns/100ps

module ipr_lvl_cmp
  import ipr_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input  wire logic                  clk,          // system clock
  input  wire logic                  resetn,       // sync reset, low
  input  wire logic [N*PRIO_W-1:0]   prio_flat,    // packed levels
  input  wire logic [N-1:0]          src_req,      // source requests
  input  wire logic [2:0]            cpu_level,    // current cpu level
  output logic [N-1:0]               src_enabled,  // level non-zero
  output logic [N-1:0]               src_eligible, // may win now
  output logic [2:0]                 top_level     // best eligible level
);

  logic [N-1:0] en_d;
  logic [N-1:0] el_d;
  logic [2:0]   top_d;
  logic [N-1:0] en_q;
  logic [N-1:0] el_q;
  logic [2:0]   top_q;

  always_comb begin
    logic [2:0] lv;
    lv    = PRIO_OFF;
    top_d = PRIO_OFF;
    for (int i = 0; i < N; i++) begin
      lv    = prio_flat[i*PRIO_W +: PRIO_W];
      en_d[i] = (lv != PRIO_OFF); // [RULE3]
      el_d[i] = src_req[i] && (lv != PRIO_OFF) && (lv > cpu_level); // [RULE3]
      if (el_d[i] && (lv > top_d)) begin
        top_d = lv;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_q  <= '1;
      el_q  <= '0;
      top_q <= PRIO_OFF;
    end else begin
      en_q  <= en_d;
      el_q  <= el_d;
      top_q <= top_d;
    end
  end

  assign src_enabled  = en_q;
  assign src_eligible = el_q;
  assign top_level    = top_q;

endmodule

/* File: hdl/ipr_regs.sv */
// Purpose: six interrupt priority control registers behind APB
// Assumes: single clock, synchronous active-low reset, APB zero wait
// Notes:   field codes are the arbitration levels; code 0 turns a
//          source off, which the eligibility stage honours

`timescale 1ns/100ps

// Summary of operation
// RULE1 - code 111 gives the source level seven, highest user level
// RULE2 - code 001 is the lowest active level; middle codes map one to one
// RULE3 - code 000 disables the source so it never wins arbitration
// RULE4 - bits outside priority fields read zero and ignore writes
// RULE5 - at reset each field loads 100: upper bit one, lower bits zero
// RULE6 - reg 10: compare7 14-12, compare6 10-8, compare5 6-4, capture6 2-0
// RULE7 - reg 11: timer6 14-12, dma4 done 10-8, 7-3 unused, compare8 2-0
// RULE8 - reg 12: timer8 14-12, i2c2 master 10-8, i2c2 slave 6-4, timer7 2-0
// RULE9 - reg 13: can2 rx 14-12, ext irq4 10-8, ext irq3 6-4, timer9 2-0
// RULE10 - reg 14: 15-11 unused, encoder 10-8, pwm 6-4, can2 event 2-0
// RULE11 - reg 15: fault a 14-12, dma5 done 6-4, 11-7 and 3-0 unused
// RULE12 - after any reset every source starts at level four
// RULE13 - software sets equal non-zero levels before enabling for one level
// RULE14 - each register is a 16-bit word; new fields act next cycle
module ipr_regs
  import ipr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,                 // 40 MHz clock
  input  wire logic              resetn,              // sync reset, low
  input  wire logic              psel,                // apb select
  input  wire logic              penable,             // apb enable
  input  wire logic              pwrite,              // apb write
  input  wire logic [ADDR_W-1:0] paddr,               // apb address
  input  wire logic [31:0]       pwdata,              // apb write data
  input  wire logic [3:0]        pstrb,               // apb byte strobes
  output logic [31:0]            prdata,              // apb read data
  output logic                   pready,              // apb ready
  output logic                   pslverr,             // apb error
  input  wire logic [19:0]       src_req,             // flag and enable
  input  wire logic [2:0]        cpu_level,           // cpu level
  output logic [19:0]            src_enabled,         // level non-zero
  output logic [19:0]            src_eligible,        // above cpu level
  output logic [2:0]             top_level,           // best level
  output logic [2:0]             compare7_priority,   // src 0
  output logic [2:0]             compare6_priority,   // src 1
  output logic [2:0]             compare5_priority,   // src 2
  output logic [2:0]             capture6_priority,   // src 3
  output logic [2:0]             timer6_priority,     // src 4
  output logic [2:0]             dma_ch4_done_priority, // src 5
  output logic [2:0]             compare8_priority,   // src 6
  output logic [2:0]             timer8_priority,     // src 7
  output logic [2:0]             i2c_unit2_master_priority, // src 8
  output logic [2:0]             i2c_unit2_slave_priority,  // src 9
  output logic [2:0]             timer7_priority,     // src 10
  output logic [2:0]             can_unit2_rx_priority, // src 11
  output logic [2:0]             ext_irq4_priority,   // src 12
  output logic [2:0]             ext_irq3_priority,   // src 13
  output logic [2:0]             timer9_priority,     // src 14
  output logic [2:0]             quad_encoder_priority, // src 15
  output logic [2:0]             pwm_event_priority,  // src 16
  output logic [2:0]             can_unit2_event_priority, // src 17
  output logic [2:0]             pwm_fault_a_priority, // src 18
  output logic [2:0]             dma_ch5_done_priority // src 19
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [15:0] prio10_q;
  logic [15:0] prio11_q;
  logic [15:0] prio12_q;
  logic [15:0] prio13_q;
  logic [15:0] prio14_q;
  logic [15:0] prio15_q;

  logic [ADDR_W-1:0] ofs;
  logic              hit10;
  logic              hit11;
  logic              hit12;
  logic              hit13;
  logic              hit14;
  logic              hit15;
  logic              addr_hit;
  logic [15:0]       rd_reg;
  logic [31:0]       rd_word;
  logic              wr_fire;
  logic              wr_ok;
  logic [15:0]       wd;
  logic [1:0]        be;
  logic [NUM_SRC*PRIO_W-1:0] prio_flat;

  assign ofs = paddr;
  assign wd  = pwdata[15:0];
  assign be  = pstrb[1:0];

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // only the low half of the word holds bits; upper strobes and
  // upper write data have nothing to land in
  always_comb begin
    hit10 = 1'b0;
    hit11 = 1'b0;
    hit12 = 1'b0;
    hit13 = 1'b0;
    hit14 = 1'b0;
    hit15 = 1'b0;
    if (ofs == ADDR_W'(OFS_PRIO_10)) begin
      hit10 = 1'b1;
    end else if (ofs == ADDR_W'(OFS_PRIO_11)) begin
      hit11 = 1'b1;
    end else if (ofs == ADDR_W'(OFS_PRIO_12)) begin
      hit12 = 1'b1;
    end else if (ofs == ADDR_W'(OFS_PRIO_13)) begin
      hit13 = 1'b1;
    end else if (ofs == ADDR_W'(OFS_PRIO_14)) begin
      hit14 = 1'b1;
    end else if (ofs == ADDR_W'(OFS_PRIO_15)) begin
      hit15 = 1'b1;
    end
  end

  assign addr_hit = hit10 | hit11 | hit12 | hit13 | hit14 | hit15;

  // stored words already have unused bits at zero [RULE4]
  always_comb begin
    if (hit10) begin
      rd_reg = prio10_q;
    end else if (hit11) begin
      rd_reg = prio11_q;
    end else if (hit12) begin
      rd_reg = prio12_q;
    end else if (hit13) begin
      rd_reg = prio13_q;
    end else if (hit14) begin
      rd_reg = prio14_q;
    end else if (hit15) begin
      rd_reg = prio15_q;
    end else begin
      rd_reg = 16'h0000;
    end
  end

  assign rd_word = {16'h0000, rd_reg}; // [RULE14]

  // ------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------
  ipr_apb_if #(
    .ADDR_W   (ADDR_W)
  ) u_apb (
    .clk      (clk),
    .resetn   (resetn),
    .psel     (psel),
    .penable  (penable),
    .paddr    (paddr),
    .rd_word  (rd_word),
    .addr_hit (addr_hit),
    .wr_fire  (wr_fire),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  assign wr_ok = wr_fire & pwrite;

  // ------------------------------------------------------------
  // register writes, one process per register
  // ------------------------------------------------------------
  // reset loads 100 in every field, i.e. level four [RULE5] [RULE12]
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prio10_q <= RST_10;
    end else if (wr_ok && hit10) begin
      prio10_q <= reg_merge(prio10_q, wd, be, MASK_10); // [RULE6] [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prio11_q <= RST_11;
    end else if (wr_ok && hit11) begin
      prio11_q <= reg_merge(prio11_q, wd, be, MASK_11); // [RULE7] [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prio12_q <= RST_12;
    end else if (wr_ok && hit12) begin
      prio12_q <= reg_merge(prio12_q, wd, be, MASK_12); // [RULE8] [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prio13_q <= RST_13;
    end else if (wr_ok && hit13) begin
      prio13_q <= reg_merge(prio13_q, wd, be, MASK_13); // [RULE9] [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prio14_q <= RST_14;
    end else if (wr_ok && hit14) begin
      prio14_q <= reg_merge(prio14_q, wd, be, MASK_14); // [RULE10] [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prio15_q <= RST_15;
    end else if (wr_ok && hit15) begin
      prio15_q <= reg_merge(prio15_q, wd, be, MASK_15); // [RULE11] [RULE4]
    end
  end

  // ------------------------------------------------------------
  // field outputs, straight from the register flops
  // ------------------------------------------------------------
  // the code is the level: 7 highest, 1 lowest [RULE1] [RULE2]
  assign compare7_priority         = field_get(prio10_q, POS_HI); // [RULE6]
  assign compare6_priority         = field_get(prio10_q, POS_MH); // [RULE6]
  assign compare5_priority         = field_get(prio10_q, POS_ML); // [RULE6]
  assign capture6_priority         = field_get(prio10_q, POS_LO); // [RULE6]
  assign timer6_priority           = field_get(prio11_q, POS_HI); // [RULE7]
  assign dma_ch4_done_priority     = field_get(prio11_q, POS_MH); // [RULE7]
  assign compare8_priority         = field_get(prio11_q, POS_LO); // [RULE7]
  assign timer8_priority           = field_get(prio12_q, POS_HI); // [RULE8]
  assign i2c_unit2_master_priority = field_get(prio12_q, POS_MH); // [RULE8]
  assign i2c_unit2_slave_priority  = field_get(prio12_q, POS_ML); // [RULE8]
  assign timer7_priority           = field_get(prio12_q, POS_LO); // [RULE8]
  assign can_unit2_rx_priority     = field_get(prio13_q, POS_HI); // [RULE9]
  assign ext_irq4_priority         = field_get(prio13_q, POS_MH); // [RULE9]
  assign ext_irq3_priority         = field_get(prio13_q, POS_ML); // [RULE9]
  assign timer9_priority           = field_get(prio13_q, POS_LO); // [RULE9]
  assign quad_encoder_priority     = field_get(prio14_q, POS_MH); // [RULE10]
  assign pwm_event_priority        = field_get(prio14_q, POS_ML); // [RULE10]
  assign can_unit2_event_priority  = field_get(prio14_q, POS_LO); // [RULE10]
  assign pwm_fault_a_priority      = field_get(prio15_q, POS_HI); // [RULE11]
  assign dma_ch5_done_priority     = field_get(prio15_q, POS_ML); // [RULE11]

  // source order matches the port comments, source 0 in the low bits
  assign prio_flat = {
    dma_ch5_done_priority,
    pwm_fault_a_priority,
    can_unit2_event_priority,
    pwm_event_priority,
    quad_encoder_priority,
    timer9_priority,
    ext_irq3_priority,
    ext_irq4_priority,
    can_unit2_rx_priority,
    timer7_priority,
    i2c_unit2_slave_priority,
    i2c_unit2_master_priority,
    timer8_priority,
    compare8_priority,
    dma_ch4_done_priority,
    timer6_priority,
    capture6_priority,
    compare5_priority,
    compare6_priority,
    compare7_priority
  };

  // ------------------------------------------------------------
  // eligibility for the arbiter
  // ------------------------------------------------------------
  // a level of zero masks the request whatever flag and enable say;
  // the registered stage costs one cycle of latency but keeps the
  // arbiter input off the bus decode path [RULE3] [RULE14]
  ipr_lvl_cmp #(
    .N            (NUM_SRC)
  ) u_cmp (
    .clk          (clk),
    .resetn       (resetn),
    .prio_flat    (prio_flat),
    .src_req      (src_req),
    .cpu_level    (cpu_level),
    .src_enabled  (src_enabled),
    .src_eligible (src_eligible),
    .top_level    (top_level)
  );

endmodule

/* File: tb/ipr_regs_props.sv */
// Purpose: concurrent checks on the priority register block ports
// Assumes: one clock, synchronous active-low reset, apb zero wait
// Notes:   arbiter checks watch the fault a source, slot 18

`timescale 1ns/100ps

module ipr_regs_props
  import ipr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,                   // clock
  input wire logic              resetn,                // reset, low
  input wire logic              psel,                  // apb select
  input wire logic              penable,               // apb enable
  input wire logic              pwrite,                // apb write
  input wire logic [ADDR_W-1:0] paddr,                 // apb address
  input wire logic [31:0]       pwdata,                // apb wdata
  input wire logic [3:0]        pstrb,                 // apb strobes
  input wire logic [31:0]       prdata,                // apb rdata
  input wire logic              pready,                // apb ready
  input wire logic              pslverr,               // apb error
  input wire logic [19:0]       src_req,               // requests
  input wire logic [2:0]        cpu_level,             // cpu level
  input wire logic [19:0]       src_enabled,           // enabled
  input wire logic [19:0]       src_eligible,          // eligible
  input wire logic [2:0]        top_level,             // best level
  input wire logic [2:0]        compare7_priority,     // src 0
  input wire logic [2:0]        pwm_fault_a_priority,  // src 18
  input wire logic [2:0]        dma_ch5_done_priority  // src 19
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // --------------------------------------------------------------
  // helper terms
  // --------------------------------------------------------------
  logic       hit;
  logic [2:0] fa_wd;
  logic       fa_elig;
  assign hit     = paddr[1:0] == 2'b00 && paddr <= ADDR_W'(20);
  assign fa_wd   = pwdata[14:12];
  assign fa_elig = src_req[18] && pwm_fault_a_priority > cpu_level;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_unused_reg15: assert property (pready && !pwrite &&
    paddr == ADDR_W'(20) |-> (prdata[15:0] & ~MASK_15) == 16'h0)
    else $error("unused bits of reg 15 read nonzero");
  a_err_map: assert property (pready |-> pslverr == !hit)
    else $error("error flag disagrees with map");
  a_fault_write: assert property (pready && pwrite &&
    paddr == ADDR_W'(20) && pstrb[1]
    |=> pwm_fault_a_priority == $past(fa_wd))
    else $error("fault a field not written");
  a_enable_zero: assert property (1'b1 |=>
    src_enabled[18] == ($past(pwm_fault_a_priority) != 3'h0))
    else $error("enable does not follow field");
  a_elig_level: assert property (1'b1 |=>
    src_eligible[18] == $past(fa_elig))
    else $error("eligibility does not follow level");
  a_top_none: assert property (src_eligible == 20'h0 |->
    top_level == 3'h0)
    else $error("top level without eligible source");
  a_reset_lvl: assert property ($rose(resetn) |->
    compare7_priority == 3'h4 && dma_ch5_done_priority == 3'h4)
    else $error("field not at level four after reset");

  c_fault_wr: cover property (pready && pwrite && paddr == ADDR_W'(20));
  c_unmapped: cover property (pready && pslverr);
  c_top7:     cover property (top_level == 3'h7);
endmodule

bind ipr_regs ipr_regs_props #(.ADDR_W(ADDR_W)) u_props (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_req(src_req), .cpu_level(cpu_level), .src_enabled(src_enabled),
  .src_eligible(src_eligible), .top_level(top_level),
  .compare7_priority(compare7_priority),
  .pwm_fault_a_priority(pwm_fault_a_priority),
  .dma_ch5_done_priority(dma_ch5_done_priority));

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the priority register block
// Assumes: apb master waits for pready under a bounded count
// Notes:   field outputs are gathered into one array by source index

`timescale 1ns/100ps

module tb_top
  import ipr_pkg::*;
;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [19:0] src_req, src_enabled, src_eligible;
  logic [2:0]  cpu_level, top_level;
  logic [2:0]  f [20];
  int          errors, check_count;

  // source index to register and field position
  localparam int SR [20] = '{0,0,0,0,1,1,1,2,2,2,2,3,3,3,3,4,4,4,5,5};
  localparam int SP [20] = '{12,8,4,0,12,8,0,12,8,4,0,12,8,4,0,8,4,0,12,4};
  localparam logic [15:0] RV [6] = '{RST_10, RST_11, RST_12,
                                     RST_13, RST_14, RST_15};
  localparam logic [15:0] MK [6] = '{MASK_10, MASK_11, MASK_12,
                                     MASK_13, MASK_14, MASK_15};

  ipr_regs uut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .cpu_level(cpu_level),
    .src_enabled(src_enabled), .src_eligible(src_eligible),
    .top_level(top_level), .compare7_priority(f[0]),
    .compare6_priority(f[1]), .compare5_priority(f[2]),
    .capture6_priority(f[3]), .timer6_priority(f[4]),
    .dma_ch4_done_priority(f[5]), .compare8_priority(f[6]),
    .timer8_priority(f[7]), .i2c_unit2_master_priority(f[8]),
    .i2c_unit2_slave_priority(f[9]), .timer7_priority(f[10]),
    .can_unit2_rx_priority(f[11]), .ext_irq4_priority(f[12]),
    .ext_irq3_priority(f[13]), .timer9_priority(f[14]),
    .quad_encoder_priority(f[15]), .pwm_event_priority(f[16]),
    .can_unit2_event_priority(f[17]), .pwm_fault_a_priority(f[18]),
    .dma_ch5_done_priority(f[19]));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task test_done;
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until pready is sampled high, released after it
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d,
           input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0, d};
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      test_done;
    end
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task t_rst;
    logic [31:0] rd;
    logic        er;
    for (int r = 0; r < 6; r++) begin
      apb(1'b0, 8'(4 * r), 16'h0, 4'h0, rd, er);
      chk("reset_word", {16'h0, RV[r]}, rd);
    end
    for (int i = 0; i < 20; i++)
      chk("reset_field", 32'h4, {29'h0, f[i]});
    chk("reset_enabled", 32'hfffff, {12'h0, src_enabled});
  endtask

  // bits 15, 11, 7 and 3 are written as ones; unused bits must read back zero
  task t_map;
    logic [31:0] rd;
    logic        er;
    logic [15:0] w;
    for (int r = 0; r < 6; r++) begin
      w = 16'h7531 ^ (16'h1111 * 16'(r));
      apb(1'b1, 8'(4 * r), w | 16'h8888, 4'h3, rd, er);
      apb(1'b0, 8'(4 * r), 16'h0, 4'h0, rd, er);
      chk("masked_word", {16'h0, w & MK[r]}, rd);
    end
    for (int i = 0; i < 20; i++) begin
      w = 16'h7531 ^ (16'h1111 * 16'(SR[i]));
      chk("field_place",
          {29'h0, w[SP[i] +: 3]}, {29'h0, f[i]});
    end
    apb(1'b1, 8'h08, 16'h0, 4'h1, rd, er);
    apb(1'b0, 8'h08, 16'h0, 4'h0, rd, er);
    chk("lane_keep", 32'h5700, rd);
  endtask

  // unmapped and misaligned places answer with error and alter nothing
  task t_err;
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 8'h18, 16'h0, 4'h0, rd, er);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, 8'h01, 16'h0, 4'h3, rd, er);
    chk("misalign_err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h00, 16'h0, 4'h0, rd, er);
    chk("no_alias", 32'h7531, rd);
  endtask

  // every code against two cpu levels, all other sources off
  task t_arb;
    logic [31:0] rd;
    logic        er;
    for (int r = 0; r < 6; r++)
      apb(1'b1, 8'(4 * r), 16'h0, 4'h3, rd, er);
    src_req <= 20'hfffff;
    for (int cl = 0; cl < 8; cl += 5) begin
      cpu_level <= 3'(cl);
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, 8'h14, 16'(c) << 12, 4'h3, rd, er);
        repeat (2) @(posedge clk);
        chk("enabled", 32'(c != 0) << 18, {12'h0, src_enabled});
        chk("eligible", 32'(c > cl) << 18,
            {12'h0, src_eligible});
        chk("top", (c > cl) ? 32'(c) : 32'h0,
            {29'h0, top_level});
      end
    end
    // one shared non-zero level, programmed before requests rise
    src_req   <= 20'h0;
    cpu_level <= 3'h2;
    for (int r = 0; r < 6; r++)
      apb(1'b1, 8'(4 * r), 16'h3333, 4'h3, rd, er);
    src_req <= 20'hfffff;
    repeat (2) @(posedge clk);
    chk("one_level_el", 32'hfffff, {12'h0, src_eligible});
    chk("one_level_top", 32'h3, {29'h0, top_level});
  endtask

  // --------------------------------------------------------------
  // clock and main sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    resetn      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    pstrb       = 4'h0;
    src_req     = 20'h0;
    cpu_level   = 3'h0;
    errors      = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_rst;
    t_map;
    t_err;
    t_arb;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_rst;
    test_done;
  end
endmodule
